// ### noload_pkg.sv
package noload_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [3:0] ADDR_ACTIVE_THR   = 4'h0;
    localparam logic [3:0] ADDR_REACTIVE_THR = 4'h1;
    localparam logic [3:0] ADDR_APPARENT_THR = 4'h2;
    localparam logic [3:0] ADDR_FLAGS        = 4'h3;
    localparam logic [3:0] ADDR_ENABLES      = 4'h4;
    localparam logic [3:0] ADDR_PHASE_STATE  = 4'h5;

    // ****************************************************************
    // Field positions and widths.
    // ****************************************************************
    localparam int THR_WIDTH    = 16;
    localparam int DATA_WIDTH   = 32;
    localparam int PHASES       = 3;
    localparam int FUND_BIT     = 1;
    localparam int APP_BIT      = 2;
    localparam int FUND_LSB     = 3;
    localparam int APP_LSB      = 6;

    localparam logic [15:0] THR_RESET   = 16'h0000;
    localparam logic [15:0] THR_MAX     = 16'hFFFF;
    localparam logic [2:0]  PHASE_RESET = 3'h0;

endpackage

// ### no_load_detector.sv
`timescale 1ns/1ps
`default_nettype none

module no_load_detector #(
    parameter int PHASES = noload_pkg::PHASES
) (
    // Clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Register port.
    input  wire logic [3:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    // Time base and per-phase accumulator increments.
    input  wire logic              tick,
    input  wire logic [PHASES-1:0] fund_active_lsb,
    input  wire logic [PHASES-1:0] fund_reactive_lsb,
    input  wire logic [PHASES-1:0] apparent_lsb,
    // Gating of accumulation and pulses.
    output logic      [PHASES-1:0] fund_accumulate_en,
    output logic      [PHASES-1:0] apparent_accumulate_en,
    // Interrupt, active low.
    output logic                   second_irq_line_n
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic [15:0]        active_noload_threshold;
        logic [15:0]        reactive_noload_threshold;
        logic [15:0]        apparent_noload_threshold;
        logic [31:0]        second_event_flags;
        logic [31:0]        second_event_enables;
        logic [PHASES-1:0]  fund_noload_phase_bits;
        logic [PHASES-1:0]  apparent_noload_phase_bits;
        logic [PHASES-1:0][15:0] fund_idle;
        logic [PHASES-1:0][15:0] app_idle;
        logic [31:0]        rdata;
    } state_type;

    state_type cur;
    state_type next_s;

    logic fund_enabled;
    logic app_enabled;
    logic [15:0] fund_limit;
    logic [PHASES-1:0] fund_inc;
    logic [PHASES-1:0] fund_enter;
    logic [PHASES-1:0] app_enter;
    logic [PHASES-1:0] next_fund_bits;
    logic [PHASES-1:0] next_app_bits;

    // Fundamental detection needs both shared thresholds nonzero; apparent detection needs only the apparent threshold nonzero.
    assign fund_enabled = (cur.active_noload_threshold != noload_pkg::THR_RESET)
                       && (cur.reactive_noload_threshold != noload_pkg::THR_RESET);
    assign app_enabled  = cur.apparent_noload_threshold != noload_pkg::THR_RESET;
    // The idle limit is the smaller of the two thresholds.
    assign fund_limit = (cur.active_noload_threshold < cur.reactive_noload_threshold)
                      ? cur.active_noload_threshold : cur.reactive_noload_threshold;

    // ****************************************************************
    // Per-phase idle timers.
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < PHASES; g++)
        begin : g_phase
            assign fund_inc[g]  = fund_active_lsb[g] | fund_reactive_lsb[g];
            // A phase enters no-load once its idle count reaches the limit.
            assign fund_enter[g] = fund_enabled && !fund_inc[g] && tick
                                && (cur.fund_idle[g] + 16'h0001 >= fund_limit);
            assign app_enter[g]  = app_enabled && !apparent_lsb[g] && tick
                                && (cur.app_idle[g] + 16'h0001 >= cur.apparent_noload_threshold);
            // Any increment leaves no-load at once; each phase alone.
            assign next_fund_bits[g] = fund_enabled
                && (fund_inc[g] ? 1'b0 : (cur.fund_noload_phase_bits[g] | fund_enter[g]));
            assign next_app_bits[g] = app_enabled
                && (apparent_lsb[g] ? 1'b0 : (cur.apparent_noload_phase_bits[g] | app_enter[g]));
            // Accumulation and pulses stop while in no-load.
            assign fund_accumulate_en[g]     = !cur.fund_noload_phase_bits[g];
            assign apparent_accumulate_en[g] = !cur.apparent_noload_phase_bits[g];
        end
    endgenerate

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb
    begin
        next_s = cur;
        next_s.rdata = 32'h0000_0000;
        for (int p = 0; p < PHASES; p++)
        begin
            if (fund_inc[p] || !fund_enabled)
                next_s.fund_idle[p] = 16'h0000;
            else if (tick && cur.fund_idle[p] != noload_pkg::THR_MAX)
                next_s.fund_idle[p] = cur.fund_idle[p] + 16'h0001;
            if (apparent_lsb[p] || !app_enabled)
                next_s.app_idle[p] = 16'h0000;
            else if (tick && cur.app_idle[p] != noload_pkg::THR_MAX)
                next_s.app_idle[p] = cur.app_idle[p] + 16'h0001;
        end
        next_s.fund_noload_phase_bits     = next_fund_bits;
        next_s.apparent_noload_phase_bits = next_app_bits;
        if (wr)
        begin
            unique case (addr)
                noload_pkg::ADDR_ACTIVE_THR:   next_s.active_noload_threshold   = wdata[15:0];
                noload_pkg::ADDR_REACTIVE_THR: next_s.reactive_noload_threshold = wdata[15:0];
                noload_pkg::ADDR_APPARENT_THR: next_s.apparent_noload_threshold = wdata[15:0];
                noload_pkg::ADDR_ENABLES:      next_s.second_event_enables      = wdata;
                // Write one to clear.
                noload_pkg::ADDR_FLAGS:        next_s.second_event_flags = cur.second_event_flags & ~wdata;
                default: ;
            endcase
        end
        // Flags set on any state change regardless of enables; set wins.
        if (next_fund_bits != cur.fund_noload_phase_bits)
            next_s.second_event_flags[noload_pkg::FUND_BIT] = 1'b1;
        if (next_app_bits != cur.apparent_noload_phase_bits)
            next_s.second_event_flags[noload_pkg::APP_BIT] = 1'b1;
        if (rd)
        begin
            unique case (addr)
                noload_pkg::ADDR_ACTIVE_THR:   next_s.rdata = {16'h0000, cur.active_noload_threshold};
                noload_pkg::ADDR_REACTIVE_THR: next_s.rdata = {16'h0000, cur.reactive_noload_threshold};
                noload_pkg::ADDR_APPARENT_THR: next_s.rdata = {16'h0000, cur.apparent_noload_threshold};
                noload_pkg::ADDR_FLAGS:        next_s.rdata = cur.second_event_flags;
                noload_pkg::ADDR_ENABLES:      next_s.rdata = cur.second_event_enables;
                noload_pkg::ADDR_PHASE_STATE:
                begin
                    next_s.rdata[noload_pkg::FUND_LSB +: PHASES] = cur.fund_noload_phase_bits;
                    next_s.rdata[noload_pkg::APP_LSB +: PHASES]  = cur.apparent_noload_phase_bits;
                end
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_s;
        end
    end

    assign rdata = cur.rdata;
    // Line low while any enabled flag is set.
    assign second_irq_line_n = ~|(cur.second_event_flags & cur.second_event_enables);

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_fund_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        (next_fund_bits != cur.fund_noload_phase_bits)
        |=> cur.second_event_flags[noload_pkg::FUND_BIT])
        else $error("fundamental flag not set");
    a_app_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        (next_app_bits != cur.apparent_noload_phase_bits)
        |=> cur.second_event_flags[noload_pkg::APP_BIT])
        else $error("apparent flag not set");
    a_fund_disable: assert property (@(posedge clk_sys) disable iff (rst)
        !fund_enabled |=> cur.fund_noload_phase_bits == '0)
        else $error("fundamental detect while disabled");
    a_app_disable: assert property (@(posedge clk_sys) disable iff (rst)
        !app_enabled |=> cur.apparent_noload_phase_bits == '0)
        else $error("apparent detect while disabled");
    a_exit_on_inc: assert property (@(posedge clk_sys) disable iff (rst)
        fund_inc[0] |=> !cur.fund_noload_phase_bits[0])
        else $error("no exit on increment");
    a_irq_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (cur.second_event_flags[noload_pkg::FUND_BIT]
         && cur.second_event_enables[noload_pkg::FUND_BIT]) |-> !second_irq_line_n)
        else $error("interrupt released early");
    a_clear_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == noload_pkg::ADDR_FLAGS && wdata[noload_pkg::APP_BIT]
         && next_app_bits == cur.apparent_noload_phase_bits)
        |=> !cur.second_event_flags[noload_pkg::APP_BIT])
        else $error("flag not cleared");

    // ****************************************************************
    // Interrupt and flag checks.
    // ****************************************************************
    a_irq_app: assert property (@(posedge clk_sys) disable iff (rst)
        (cur.second_event_flags[noload_pkg::APP_BIT]
         && cur.second_event_enables[noload_pkg::APP_BIT]) |-> !second_irq_line_n)
        else $error("apparent interrupt not driven");
    a_irq_masked: assert property (@(posedge clk_sys) disable iff (rst)
        ((cur.second_event_flags & cur.second_event_enables) == '0) |-> second_irq_line_n)
        else $error("interrupt driven with no enabled flag");
    a_clear_fund: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == noload_pkg::ADDR_FLAGS && wdata[noload_pkg::FUND_BIT]
         && next_fund_bits == cur.fund_noload_phase_bits)
        |=> !cur.second_event_flags[noload_pkg::FUND_BIT])
        else $error("fundamental flag not cleared");
    // A flag may only drop through a write to the flag register.
    a_fund_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        (cur.second_event_flags[noload_pkg::FUND_BIT]
         && !(wr && addr == noload_pkg::ADDR_FLAGS))
        |=> cur.second_event_flags[noload_pkg::FUND_BIT])
        else $error("fundamental flag lost");
    a_app_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        (cur.second_event_flags[noload_pkg::APP_BIT]
         && !(wr && addr == noload_pkg::ADDR_FLAGS))
        |=> cur.second_event_flags[noload_pkg::APP_BIT])
        else $error("apparent flag lost");
    // A flag is only raised by a change of phase state.
    a_fund_no_spurious: assert property (@(posedge clk_sys) disable iff (rst)
        (!cur.second_event_flags[noload_pkg::FUND_BIT]
         && next_fund_bits == cur.fund_noload_phase_bits)
        |=> !cur.second_event_flags[noload_pkg::FUND_BIT])
        else $error("fundamental flag raised with no change");
    a_app_no_spurious: assert property (@(posedge clk_sys) disable iff (rst)
        (!cur.second_event_flags[noload_pkg::APP_BIT]
         && next_app_bits == cur.apparent_noload_phase_bits)
        |=> !cur.second_event_flags[noload_pkg::APP_BIT])
        else $error("apparent flag raised with no change");

    // ****************************************************************
    // Register port and zero-threshold checks.
    // ****************************************************************
    a_fund_state_read: assert property (@(posedge clk_sys) disable iff (rst)
        (rd && addr == noload_pkg::ADDR_PHASE_STATE)
        |=> rdata[noload_pkg::FUND_LSB +: PHASES] == $past(cur.fund_noload_phase_bits))
        else $error("fundamental phase state misread");
    a_app_state_read: assert property (@(posedge clk_sys) disable iff (rst)
        (rd && addr == noload_pkg::ADDR_PHASE_STATE)
        |=> rdata[noload_pkg::APP_LSB +: PHASES] == $past(cur.apparent_noload_phase_bits))
        else $error("apparent phase state misread");
    a_flags_read: assert property (@(posedge clk_sys) disable iff (rst)
        (rd && addr == noload_pkg::ADDR_FLAGS) |=> rdata == $past(cur.second_event_flags))
        else $error("flag register misread");
    a_active_thr_write: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == noload_pkg::ADDR_ACTIVE_THR)
        |=> cur.active_noload_threshold == 16'($past(wdata)))
        else $error("active threshold not written");
    a_reactive_thr_write: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == noload_pkg::ADDR_REACTIVE_THR)
        |=> cur.reactive_noload_threshold == 16'($past(wdata)))
        else $error("reactive threshold not written");
    a_app_thr_write: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == noload_pkg::ADDR_APPARENT_THR)
        |=> cur.apparent_noload_threshold == 16'($past(wdata)))
        else $error("apparent threshold not written");
    a_enables_write: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == noload_pkg::ADDR_ENABLES)
        |=> cur.second_event_enables == $past(wdata))
        else $error("enable register not written");
    // Read data stand for one cycle only, so an idle port reads zero.
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !rd |=> rdata == '0)
        else $error("read data outside the answer cycle");
    a_fund_both_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (cur.active_noload_threshold == noload_pkg::THR_RESET
         && cur.reactive_noload_threshold == noload_pkg::THR_RESET)
        |=> cur.fund_noload_phase_bits == '0)
        else $error("fundamental detect with zero thresholds");

    // ****************************************************************
    // Per-phase checks.
    // ****************************************************************
    generate
        for (g = 0; g < PHASES; g++)
        begin : g_check
            // A cycle out of no-load that brings no quiet tick.
            sequence s_fund_no_quiet_tick;
                !cur.fund_noload_phase_bits[g]
                && !(tick && fund_enabled && !fund_inc[g]);
            endsequence
            sequence s_app_no_quiet_tick;
                !cur.apparent_noload_phase_bits[g]
                && !(tick && app_enabled && !apparent_lsb[g]);
            endsequence
            // A phase whose idle count is still short of its limit.
            sequence s_fund_short;
                !cur.fund_noload_phase_bits[g]
                && (cur.fund_idle[g] < fund_limit - 16'h0001);
            endsequence
            sequence s_app_short;
                !cur.apparent_noload_phase_bits[g]
                && (cur.app_idle[g] < cur.apparent_noload_threshold - 16'h0001);
            endsequence
            // A phase in no-load that stays enabled and quiet.
            sequence s_fund_held;
                cur.fund_noload_phase_bits[g] && fund_enabled && !fund_inc[g];
            endsequence
            sequence s_app_held;
                cur.apparent_noload_phase_bits[g] && app_enabled && !apparent_lsb[g];
            endsequence

            a_fund_tick_entry: assert property (@(posedge clk_sys) disable iff (rst)
                s_fund_no_quiet_tick |=> !cur.fund_noload_phase_bits[g])
                else $error("fundamental entry off a quiet tick");
            a_app_tick_entry: assert property (@(posedge clk_sys) disable iff (rst)
                s_app_no_quiet_tick |=> !cur.apparent_noload_phase_bits[g])
                else $error("apparent entry off a quiet tick");
            a_fund_no_early: assert property (@(posedge clk_sys) disable iff (rst)
                s_fund_short |=> !cur.fund_noload_phase_bits[g])
                else $error("fundamental entry before the limit");
            a_app_no_early: assert property (@(posedge clk_sys) disable iff (rst)
                s_app_short |=> !cur.apparent_noload_phase_bits[g])
                else $error("apparent entry before the limit");
            a_fund_gate: assert property (@(posedge clk_sys) disable iff (rst)
                s_fund_held |=> !fund_accumulate_en[g])
                else $error("fundamental gating wrong");
            a_app_gate: assert property (@(posedge clk_sys) disable iff (rst)
                s_app_held |=> !apparent_accumulate_en[g])
                else $error("apparent gating wrong");
            a_fund_exit: assert property (@(posedge clk_sys) disable iff (rst)
                fund_inc[g] |=> fund_accumulate_en[g])
                else $error("fundamental phase kept in no-load");
            a_app_exit: assert property (@(posedge clk_sys) disable iff (rst)
                apparent_lsb[g] |=> apparent_accumulate_en[g])
                else $error("apparent phase kept in no-load");
        end
    endgenerate

endmodule
`default_nettype wire

// ### energy_source.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Far-side model: time base and per-phase energy increments.
// ****************************************************************
module energy_source #(
    parameter int TICK_DIV = 4
) (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Phases held silent by the bench.
    input  wire logic [2:0] quiet_fund,
    input  wire logic [2:0] quiet_app,
    // Increments and time base.
    output logic            tick,
    output logic      [2:0] fund_active_lsb,
    output logic      [2:0] fund_reactive_lsb,
    output logic      [2:0] apparent_lsb
);
    int count;

    always_ff @(posedge clk_sys)
    begin
        count <= (rst || count == TICK_DIV - 1) ? 0 : count + 1;
        tick <= !rst && count == TICK_DIV - 1;
        fund_active_lsb <= (!rst && count == 1) ? ~quiet_fund : 3'h0;
        fund_reactive_lsb <= (!rst && count == 2) ? ~quiet_fund : 3'h0;
        apparent_lsb <= (!rst && count == 1) ? ~quiet_app : 3'h0;
    end
endmodule

`default_nettype wire

// ### no_load_detector_tb.sv
`timescale 1ns/1ps
`default_nettype none

module no_load_detector_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        tick;
    logic [2:0]  fal, frl, apl, fund_en, app_en;
    logic [2:0]  quiet_fund = 3'h0;
    logic [2:0]  quiet_app = 3'h0;
    logic        irq_n;
    logic [31:0] seen;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    typedef struct { logic [3:0] a; logic [31:0] d; logic [31:0] e; } row_type;
    row_type rows [4] = '{'{4'h0, 32'h0000FFFF, 32'h0000FFFF},
                          '{4'h2, 32'h1234ABCD, 32'h0000ABCD},
                          '{4'h4, 32'h00000006, 32'h00000006},
                          '{4'hF, 32'hFFFFFFFF, 32'h00000000}};

    always #12.5 clk_sys = ~clk_sys;

    energy_source u_src (.clk_sys(clk_sys), .rst(rst), .quiet_fund(quiet_fund),
        .quiet_app(quiet_app), .tick(tick), .fund_active_lsb(fal),
        .fund_reactive_lsb(frl), .apparent_lsb(apl));

    no_load_detector u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .tick(tick), .fund_active_lsb(fal),
        .fund_reactive_lsb(frl), .apparent_lsb(apl), .fund_accumulate_en(fund_en),
        .apparent_accumulate_en(app_en), .second_irq_line_n(irq_n));

    task automatic test_done();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check("irq after reset", irq_n, 1'b1);
        check("fund enables after reset", fund_en, 3'h7);
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, seen);
            check("register row", seen, rows[i].e);
        end
        wr_reg(4'h0, 32'h5);
        wr_reg(4'h1, 32'h8);
        wr_reg(4'h2, 32'h6);
        settle(60);
        check("fund enables busy", fund_en, 3'h7);
        check("irq busy", irq_n, 1'b1);
        quiet_fund <= 3'h1;
        quiet_app <= 3'h2;
        settle(60);
        check("fund enables idle", fund_en, 3'h6);
        check("app enables idle", app_en, 3'h5);
        check("irq idle", irq_n, 1'b0);
        rd_reg(4'h3, seen);
        check("flags", seen, 32'h6);
        rd_reg(4'h5, seen);
        check("phase state", seen, 32'h88);
        wr_reg(4'h3, 32'h2);
        settle(1);
        check("irq half cleared", irq_n, 1'b0);
        wr_reg(4'h3, 32'h4);
        settle(1);
        check("irq cleared", irq_n, 1'b1);
        quiet_fund <= 3'h0;
        quiet_app <= 3'h0;
        settle(20);
        check("enables resumed", {fund_en, app_en}, 6'h3F);
        rd_reg(4'h5, seen);
        check("phase state exit", seen, 32'h0);
        check("irq on exit", irq_n, 1'b0);
        wr_reg(4'h3, 32'h6);
        wr_reg(4'h4, 32'h0);
        quiet_fund <= 3'h4;
        settle(60);
        rd_reg(4'h3, seen);
        check("masked flag", seen, 32'h2);
        check("masked irq", irq_n, 1'b1);
        wr_reg(4'h0, 32'h0);
        wr_reg(4'h3, 32'h6);
        settle(60);
        check("one zero threshold", fund_en, 3'h7);
        wr_reg(4'h1, 32'h0);
        settle(60);
        check("both zero thresholds", fund_en, 3'h7);
        wr_reg(4'h2, 32'h0);
        quiet_app <= 3'h7;
        settle(60);
        check("zero apparent threshold", app_en, 3'h7);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check("irq after second reset", irq_n, 1'b1);
        check("enables out after second reset", {fund_en, app_en}, 6'h3F);
        rd_reg(4'h4, seen);
        check("enables after second reset", seen, 32'h0);
        test_done();
    end
endmodule

`default_nettype wire
